/* File: dsp_pkg.sv */
// Constants and types of the shared serial port pin logic, and its input synchroniser.
// Assumes one 50 MHz ref_clk domain; every pin arrives asynchronously to it.
// Notes on behaviour
// - SPI frames exist only while the active-low frame select is held low.
// - Input bits taken on rising SCLK, output bits changed on falling SCLK.
// - Addressed data shifts out on the open-drain data pin, new bit per falling edge.
// - Alert pin asserts on limit events; polarity selectable, active low by default.
// - Strap low gives 1001 000, floating 1001 010, high 1001 011.
// - Address latches on the eighth SCL cycle of the second valid communication.
// - After latching, strap pin changes no longer affect the address.

`timescale 1ns/1ns

package dsp_pkg;
   // ----------------------------------------------------------------
   // Strap levels as reported by the three-level pad
   // ----------------------------------------------------------------
   localparam logic [1:0] STRAP_LOW = 2'h0;
   localparam logic [1:0] STRAP_FLOAT = 2'h1;
   localparam logic [1:0] STRAP_HIGH = 2'h2;

   // ----------------------------------------------------------------
   // Slave addresses and framing counts
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_LOW = 7'h48;
   localparam logic [6:0] ADDR_FLOAT = 7'h4a;
   localparam logic [6:0] ADDR_HIGH = 7'h4b;
   localparam logic [3:0] I2C_LATCH_CYCLE = 4'h8;
   localparam logic [1:0] I2C_VALID_NEEDED = 2'h2;
   localparam logic [2:0] SPI_LAST_BIT = 3'h7;
   localparam logic ALERT_POL_RESET = 1'b0;
   // Idle bus levels of cs_n, sclk and sda; pull-ups hold them high
   localparam logic [2:0] PINS_IDLE = 3'h7;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic sda;
   } dsp_pins_s;

   typedef enum logic [1:0] {I2C_IDLE, I2C_ADDR, I2C_DONE} dsp_i2c_e;

   function automatic logic [6:0] dsp_strap_addr(input logic [1:0] lvl);
      case (lvl)
         STRAP_LOW: dsp_strap_addr = ADDR_LOW;
         STRAP_FLOAT: dsp_strap_addr = ADDR_FLOAT;
         default: dsp_strap_addr = ADDR_HIGH;
      endcase
   endfunction : dsp_strap_addr
endpackage : dsp_pkg

// Two-stage synchroniser; only the second stage leaves the module.
module dsp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         // Idle level, so no false pin edge follows reset
         meta_r <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : dsp_sync

/* File: dsp_port.sv */
// Pin logic of the shared SPI / I2C serial port: framing, edges, address strap, alert.
// Assumes the host drives SCLK/SCL; pins are sampled by ref_clk through synchronisers.
`timescale 1ns/1ns
module dsp_port
   import dsp_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Serial pins
   input wire logic cs_n_pin,
   input wire logic sclk_pin,
   input wire logic sda_pin,
   input wire logic [1:0] strap_lvl,
   output logic dout_oe,
   // SPI user side
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte,
   output logic rx_valid,
   // I2C user side
   output logic [6:0] i2c_addr,
   output logic addr_locked,
   output logic addr_hit,
   output logic addr_rw,
   // Alert
   input wire logic limit_exceeded,
   input wire logic alert_active_high,
   output logic alert_oe
);
   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   dsp_pins_s pins_s;
   dsp_pins_s pins_d_r;
   logic [1:0] strap_s;

   dsp_sync #(.W(3), .RST_VAL(PINS_IDLE)) u_pin_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d({cs_n_pin, sclk_pin, sda_pin}),
      .q(pins_s)
   );

   dsp_sync #(.W(2)) u_strap_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d(strap_lvl),
      .q(strap_s)
   );

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pins_d_r <= PINS_IDLE;
      end else begin
         pins_d_r <= pins_s;
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic sda_fall;
   logic sda_rise;
   assign sclk_rise = pins_s.sclk & ~pins_d_r.sclk;
   assign sclk_fall = ~pins_s.sclk & pins_d_r.sclk;
   assign cs_fall = ~pins_s.cs_n & pins_d_r.cs_n;
   assign sda_fall = ~pins_s.sda & pins_d_r.sda;
   assign sda_rise = pins_s.sda & ~pins_d_r.sda;

   // ----------------------------------------------------------------
   // SPI framing and shifting
   // ----------------------------------------------------------------
   logic [7:0] spi_rx_r, spi_rx_nxt;
   logic [2:0] spi_bit_r, spi_bit_nxt;
   logic [7:0] spi_tx_r, spi_tx_nxt;
   logic dout_oe_r, dout_oe_nxt;
   logic [7:0] rx_byte_r, rx_byte_nxt;
   logic rx_valid_r, rx_valid_nxt;

   always_comb begin
      spi_rx_nxt = spi_rx_r;
      spi_bit_nxt = spi_bit_r;
      spi_tx_nxt = spi_tx_r;
      rx_byte_nxt = rx_byte_r;
      rx_valid_nxt = 1'b0;
      if (pins_s.cs_n) begin
         spi_bit_nxt = '0;
      end else if (cs_fall) begin
         spi_bit_nxt = '0;
         spi_tx_nxt = tx_byte;
      end else begin
         if (sclk_rise) begin
            spi_rx_nxt = {spi_rx_r[6:0], pins_s.sda};
            spi_bit_nxt = spi_bit_r + 3'h1;
            if (spi_bit_r == SPI_LAST_BIT) begin
               rx_byte_nxt = {spi_rx_r[6:0], pins_s.sda};
               rx_valid_nxt = 1'b1;
            end
         end
         if (sclk_fall) begin
            // Next byte is fetched once a full byte has gone out
            if (spi_bit_r == '0) begin
               spi_tx_nxt = tx_byte;
            end else begin
               spi_tx_nxt = {spi_tx_r[6:0], 1'b0};
            end
         end
      end
      // Open drain: pull low only inside a frame and for a zero bit
      dout_oe_nxt = ~pins_s.cs_n & ~spi_tx_nxt[7];
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         spi_rx_r <= '0;
         spi_bit_r <= '0;
         spi_tx_r <= '1;
         dout_oe_r <= 1'b0;
         rx_byte_r <= '0;
         rx_valid_r <= 1'b0;
      end else begin
         spi_rx_r <= spi_rx_nxt;
         spi_bit_r <= spi_bit_nxt;
         spi_tx_r <= spi_tx_nxt;
         dout_oe_r <= dout_oe_nxt;
         rx_byte_r <= rx_byte_nxt;
         rx_valid_r <= rx_valid_nxt;
      end
   end

   // ----------------------------------------------------------------
   // I2C address phase and deferred address latch
   // ----------------------------------------------------------------
   dsp_i2c_e i2c_st_r, i2c_st_nxt;
   logic [3:0] i2c_cnt_r, i2c_cnt_nxt;
   logic [7:0] i2c_sh_r, i2c_sh_nxt;
   logic [1:0] seen_r, seen_nxt;
   logic locked_r, locked_nxt;
   logic [6:0] addr_lat_r, addr_lat_nxt;
   logic [6:0] i2c_addr_r, i2c_addr_nxt;
   logic hit_r, hit_nxt;
   logic rw_r, rw_nxt;
   logic [6:0] live_addr;
   logic [6:0] cur_addr;
   logic [7:0] sh_next;

   // Host keeps frame select high in I2C mode, so a low select blocks I2C.
   assign live_addr = dsp_strap_addr(strap_s);
   assign cur_addr = locked_r ? addr_lat_r : live_addr;
   assign sh_next = {i2c_sh_r[6:0], pins_s.sda};

   always_comb begin
      i2c_st_nxt = i2c_st_r;
      i2c_cnt_nxt = i2c_cnt_r;
      i2c_sh_nxt = i2c_sh_r;
      seen_nxt = seen_r;
      locked_nxt = locked_r;
      addr_lat_nxt = addr_lat_r;
      hit_nxt = 1'b0;
      rw_nxt = rw_r;
      if (!pins_s.cs_n) begin
         i2c_st_nxt = I2C_IDLE;
      end else if (pins_s.sclk && sda_fall) begin
         // Start or repeated start
         i2c_st_nxt = I2C_ADDR;
         i2c_cnt_nxt = '0;
      end else if (pins_s.sclk && sda_rise) begin
         i2c_st_nxt = I2C_IDLE;
      end else begin
         case (i2c_st_r)
            I2C_IDLE: begin
            end
            I2C_ADDR: begin
               if (sclk_rise) begin
                  i2c_sh_nxt = sh_next;
                  i2c_cnt_nxt = i2c_cnt_r + 4'h1;
                  if (i2c_cnt_r + 4'h1 == I2C_LATCH_CYCLE) begin
                     i2c_st_nxt = I2C_DONE;
                     if (sh_next[7:1] == cur_addr) begin
                        hit_nxt = 1'b1;
                        rw_nxt = sh_next[0];
                        if (!locked_r) begin
                           seen_nxt = seen_r + 2'h1;
                           if (seen_r + 2'h1 == I2C_VALID_NEEDED) begin
                              locked_nxt = 1'b1;
                              addr_lat_nxt = live_addr;
                           end
                        end
                     end
                  end
               end
            end
            I2C_DONE: begin
            end
            default: i2c_st_nxt = I2C_IDLE;
         endcase
      end
      i2c_addr_nxt = locked_nxt ? addr_lat_nxt : live_addr;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         i2c_st_r <= I2C_IDLE;
         i2c_cnt_r <= '0;
         i2c_sh_r <= '0;
         seen_r <= '0;
         locked_r <= 1'b0;
         addr_lat_r <= ADDR_LOW;
         i2c_addr_r <= ADDR_LOW;
         hit_r <= 1'b0;
         rw_r <= 1'b0;
      end else begin
         i2c_st_r <= i2c_st_nxt;
         i2c_cnt_r <= i2c_cnt_nxt;
         i2c_sh_r <= i2c_sh_nxt;
         seen_r <= seen_nxt;
         locked_r <= locked_nxt;
         addr_lat_r <= addr_lat_nxt;
         i2c_addr_r <= i2c_addr_nxt;
         hit_r <= hit_nxt;
         rw_r <= rw_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Alert output
   // ----------------------------------------------------------------
   logic alert_oe_r, alert_oe_nxt;

   // Active high releases the pin on an event; active low pulls it down
   always_comb begin
      alert_oe_nxt = alert_active_high ? ~limit_exceeded : limit_exceeded;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         alert_oe_r <= ALERT_POL_RESET;
      end else begin
         alert_oe_r <= alert_oe_nxt;
      end
   end

   assign dout_oe = dout_oe_r;
   assign rx_byte = rx_byte_r;
   assign rx_valid = rx_valid_r;
   assign i2c_addr = i2c_addr_r;
   assign addr_locked = locked_r;
   assign addr_hit = hit_r;
   assign addr_rw = rw_r;
   assign alert_oe = alert_oe_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_frame_idle;
      pins_s.cs_n;
   endsequence

   a_frame_gate_rx: assert property (s_frame_idle |=> !rx_valid_r)
      else $error("Byte received with frame select high");
   a_frame_gate_dout: assert property (s_frame_idle |=> !dout_oe_r)
      else $error("Data pin driven outside a frame");
   a_rise_capture: assert property (!pins_s.cs_n && !cs_fall && sclk_rise
      |=> spi_rx_r[0] == $past(pins_s.sda))
      else $error("Input bit not taken on rising clock");
   a_fall_hold: assert property (!pins_s.cs_n && !cs_fall && !sclk_fall
      |=> spi_tx_r == $past(spi_tx_r))
      else $error("Output bit changed without falling clock");
   a_alert_polarity: assert property (1'b1
      |=> alert_oe_r == ($past(alert_active_high) ^ $past(limit_exceeded)))
      else $error("Alert drive does not follow event and polarity");
   a_strap_decode: assert property (!locked_r |-> ##1 (locked_r
      || i2c_addr_r == dsp_strap_addr($past(strap_s))))
      else $error("Unlatched address differs from strap decode");
   a_latch_second: assert property ($rose(locked_r)
      |-> seen_r == I2C_VALID_NEEDED && $past(i2c_cnt_r) == 4'h7)
      else $error("Address latched outside second valid eighth cycle");
   a_latch_holds: assert property (locked_r |=> locked_r
      && addr_lat_r == $past(addr_lat_r) && i2c_addr_r == addr_lat_r)
      else $error("Latched address changed");
   // Shift register holds the matched byte while the phase sits in its done state
   a_hit_live: assert property (hit_r && !$past(locked_r)
      |-> i2c_sh_r[7:1] == $past(live_addr))
      else $error("Pre-latch hit not against strap decode");
endmodule : dsp_port

/* File: dsp_host.sv */
// Host model: SPI or I2C master driving the shared serial pins.
// Assumes pacing by ref_clk; SDA has a pull-up, so a released line reads 1.
`timescale 1ns/1ns
module dsp_host
   import dsp_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Pins
   output dsp_pins_s pins,
   input wire logic dout_oe
);
   initial begin
      pins = '{cs_n: 1'b1, sclk: 1'b0, sda: 1'b1};
   end

   // Half an SPI link period, 160 ns per SPI bit
   task automatic half();
      repeat (4) @(negedge ref_clk);
   endtask : half

   // SCLK rests low, so the first edge in a frame is a rising one
   task automatic spi_frame(input logic [7:0] mosi, input int nbits, output logic [7:0] miso);
      miso = 8'h00;
      half();
      pins.sclk = 1'b0;
      half();
      pins.cs_n = 1'b0;
      half();
      for (int i = 7; i > 7 - nbits; i--) begin
         pins.sda = mosi[i];
         half();
         pins.sclk = 1'b1;
         repeat (2) @(negedge ref_clk);
         miso[i] = ~dout_oe;
         repeat (2) @(negedge ref_clk);
         pins.sclk = 1'b0;
      end
      half();
      pins.cs_n = 1'b1;
      pins.sda = 1'b1;
   endtask : spi_frame

   // START, eight bits, released ack slot, STOP
   task automatic i2c_phase(input logic [7:0] b);
      half();
      pins.cs_n = 1'b1;
      pins.sclk = 1'b1;
      pins.sda = 1'b1;
      half();
      pins.sda = 1'b0;
      half();
      for (int i = 8; i >= 0; i--) begin
         pins.sclk = 1'b0;
         half();
         pins.sda = (i > 0) ? b[i-1] : 1'b1;
         half();
         pins.sclk = 1'b1;
         half();
      end
      pins.sclk = 1'b0;
      pins.sda = 1'b0;
      half();
      pins.sclk = 1'b1;
      half();
      pins.sda = 1'b1;
   endtask : i2c_phase
endmodule : dsp_host

/* File: dsp_port_tb.sv */
// Self-checking bench of the serial port pin logic.
// Assumes dsp_host drives the pins; all other inputs come from here.
`timescale 1ns/1ns
module dsp_port_tb;
   import dsp_pkg::*;
   logic ref_clk, rst, dout_oe, rx_valid, addr_locked, addr_hit, addr_rw;
   logic limit_exceeded, alert_active_high, alert_oe;
   logic [1:0] strap_lvl;
   logic [7:0] tx_byte, rx_byte, got;
   logic [6:0] i2c_addr;
   logic [31:0] seed = 32'h3b1b;
   logic [31:0] r;
   dsp_pins_s pins;
   int num_errors = 0;
   int checks_done = 0;
   int n_rx = 0;
   int n_hit = 0;
   int cycles = 0;
   int k;

   dsp_host host (.ref_clk(ref_clk), .pins(pins), .dout_oe(dout_oe));
   dsp_port dut (.ref_clk(ref_clk), .rst(rst), .cs_n_pin(pins.cs_n), .sclk_pin(pins.sclk),
      .sda_pin(pins.sda), .strap_lvl(strap_lvl), .dout_oe(dout_oe), .tx_byte(tx_byte),
      .rx_byte(rx_byte), .rx_valid(rx_valid), .i2c_addr(i2c_addr), .addr_locked(addr_locked),
      .addr_hit(addr_hit), .addr_rw(addr_rw), .limit_exceeded(limit_exceeded),
      .alert_active_high(alert_active_high), .alert_oe(alert_oe));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // ------------------------------------------------------------
   // Pulse counters and hang guard
   // ------------------------------------------------------------
   // Pulses are counted mid-cycle, away from the edge that launches them
   always @(negedge ref_clk) begin
      if (rx_valid === 1'b1) n_rx++;
      if (addr_hit === 1'b1) n_hit++;
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         give_verdict();
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic logic [6:0] exp_addr(input logic [1:0] lvl);
      return (lvl == 2'h0) ? ADDR_LOW : (lvl == 2'h1) ? ADDR_FLOAT : ADDR_HIGH;
   endfunction : exp_addr

   // Open-drain enable pulls low: low-active alert drives on an event
   function automatic logic [7:0] exp_alert(input logic ev, input logic hi);
      return {7'h00, ev ^ hi};
   endfunction : exp_alert

   task automatic chk(input logic [7:0] got_v, input logic [7:0] exp_v, input string what);
      checks_done++;
      if (got_v !== exp_v) begin
         num_errors++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got_v, exp_v);
      end
   endtask : chk

   task automatic i2c_try(input logic [7:0] b, input int hits);
      k = n_hit;
      host.i2c_phase(b);
      chk(8'(n_hit - k), 8'(hits), "address hits");
   endtask : i2c_try

   task automatic give_verdict();
      $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      strap_lvl = 2'h0;
      tx_byte = 8'h00;
      limit_exceeded = 1'b0;
      alert_active_high = 1'b0;
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      repeat (6) @(negedge ref_clk);
      chk({1'b0, i2c_addr}, {1'b0, ADDR_LOW}, "address after reset");
      chk({7'h00, alert_oe}, 8'h00, "alert after reset");
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         limit_exceeded = r[0];
         alert_active_high = (i < 8) ? 1'b0 : r[1];
         @(negedge ref_clk);
         chk({7'h00, alert_oe}, exp_alert(r[0], alert_active_high), "alert level");
      end
      $display("alert test done");
      for (int s = 0; s < 4; s++) begin
         strap_lvl = 2'(s);
         repeat (6) @(negedge ref_clk);
         chk({1'b0, i2c_addr}, {1'b0, exp_addr(2'(s))}, "strap decode");
      end
      $display("strap test done");
      k = n_rx;
      tx_byte = 8'h5a;
      host.spi_frame(8'ha5, 4, got);
      chk(8'(n_rx - k), 8'h00, "partial byte count");
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         if (i == 0) r[15:0] = 16'h00ff;
         tx_byte = r[7:0];
         k = n_rx;
         host.spi_frame(r[15:8], 8, got);
         repeat (6) @(negedge ref_clk);
         chk(got, r[7:0], "spi out");
         chk(rx_byte, r[15:8], "spi in");
         chk(8'(n_rx - k), 8'h01, "spi byte count");
         chk({7'h00, dout_oe}, 8'h00, "dout released");
      end
      $display("spi test done");
      strap_lvl = 2'h1;
      repeat (6) @(negedge ref_clk);
      i2c_try({ADDR_FLOAT, 1'b0}, 1);
      chk({7'h00, addr_locked}, 8'h00, "lock after one");
      i2c_try({ADDR_LOW, 1'b0}, 0);
      i2c_try({ADDR_FLOAT, 1'b1}, 1);
      chk({7'h00, addr_locked}, 8'h01, "lock after two");
      chk({7'h00, addr_rw}, 8'h01, "read bit");
      strap_lvl = 2'h2;
      repeat (6) @(negedge ref_clk);
      chk({1'b0, i2c_addr}, {1'b0, ADDR_FLOAT}, "latched address");
      i2c_try({ADDR_HIGH, 1'b0}, 0);
      i2c_try({ADDR_FLOAT, 1'b0}, 1);
      chk({7'h00, addr_rw}, 8'h00, "write bit");
      $display("i2c test done");
      // Mid-run reset drops the latch; strap is high by now
      rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      repeat (6) @(negedge ref_clk);
      chk({7'h00, addr_locked}, 8'h00, "lock after reset");
      chk({1'b0, i2c_addr}, {1'b0, ADDR_HIGH}, "strap after reset");
      chk({7'h00, dout_oe}, 8'h00, "dout after reset");
      $display("reset test done");
      give_verdict();
   end
endmodule : dsp_port_tb
